/* inc/uecd_pkg.sv */
// Constants, setup layouts and state codes of the ultrasonic echo detector
package uecd_pkg;

  // Data widths
  localparam int ENV_W  = 8;
  localparam int RAW_W  = 10;
  localparam int TEMP_W = 10;
  localparam int NRG_W  = 16;
  localparam int CNT_W  = 10;

  // Noise thresholds by field code
  localparam logic [ENV_W-1:0] NOISE_THR_00 = 8'h10;
  localparam logic [ENV_W-1:0] NOISE_THR_01 = 8'h20;
  localparam logic [ENV_W-1:0] NOISE_THR_10 = 8'h40;
  localparam logic [ENV_W-1:0] NOISE_THR_11 = 8'h80;
  localparam logic [ENV_W-1:0] ATG_NOISE_LEVEL = 8'h80;

  // Debounce and pulse lengths in drive periods
  localparam int DEB_ON_PERIODS      = 3;
  localparam int DEB_OFF_PERIODS     = 16;
  localparam int SHORT_PULSE_PERIODS = 4;

  // Near-range window in envelope samples
  localparam logic [CNT_W-1:0] NF_WINDOW_SAMPLES = 10'h040;

  // Temperature settle delay
  localparam int CLK_MHZ          = 25;
  localparam int TSENS_DEL_US     = 2000;
  localparam int TSENS_DEL_CYCLES = TSENS_DEL_US * CLK_MHZ;

  // Setup write targets
  localparam logic [1:0] SEL_MEAS = 2'h0;
  localparam logic [1:0] SEL_THRA = 2'h1;
  localparam logic [1:0] SEL_THRB = 2'h2;

  // Measurement setup layout, bit 7 downward
  typedef struct packed {
    logic [1:0] spare;
    logic       thr_sel;
    logic       ringing_source_select;
    logic       every_peak_enable;
    logic       first_peak_enable;
    logic [1:0] noise_cfg;
  } uecd_meas_t;

  // Status word seen by status read and status sequence
  typedef struct packed {
    logic noise_during;
    logic noise_before;
    logic wr_ok_thrb;
    logic wr_ok_thra;
    logic wr_ok_meas;
  } uecd_status_t;

  // Reset values
  localparam logic [7:0] MEAS_RESET = 8'h04;
  localparam logic [7:0] THRA_RESET = 8'h40;
  localparam logic [7:0] THRB_RESET = 8'h60;
  localparam logic [7:0] CAL_RESET  = 8'h00;

  // Measurement sequencing
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_NOISE = 3'b010,
    ST_MEAS  = 3'b100
  } uecd_state_t;

endpackage

/* core/uecd_tick_count.sv */
// Drive-period counter that reports when a fixed count is reached
`timescale 1ns/1ps
`default_nettype none
module uecd_tick_count #(
  parameter int unsigned LIMIT = 3
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic clear,
  input  wire logic tick,
  // Result
  output logic      done
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] cnt_reg;

  // Count ticks while not cleared, saturating at the limit
  always_ff @(posedge clk) begin
    if (rst || (ce && clear)) begin
      cnt_reg <= '0;
    end else if (ce && tick && cnt_reg != LIM) begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  assign done = (cnt_reg == LIM);
endmodule
`default_nettype wire

/* core/uecd_top.sv */
// Echo detection, noise checks, setups and temperature readout of the sensor back end
`timescale 1ns/1ps
`default_nettype none
module uecd_top #(
  parameter int unsigned TEMP_DELAY_CYCLES = uecd_pkg::TSENS_DEL_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                            CLOCK,
  input  wire logic                            RESET,
  input  wire logic                            CE,
  // Single IO line, open drain
  input  wire logic                            IO_IN,
  output var  logic                            IO_OUT,
  output var  logic                            IO_OE,
  // Decoded command events from the IO framer
  input  wire logic                            MEAS_START,
  input  wire logic                            MEAS_END,
  input  wire logic                            WAKE,
  // Setup writes from the IO framer, calibration from the cells
  input  wire logic                            SETUP_WR,
  input  wire logic [1:0]                      SETUP_SEL,
  input  wire logic [7:0]                      SETUP_DATA,
  input  wire logic                            SETUP_PARITY_OK,
  input  wire logic [7:0]                      NVM_CAL,
  // Signal path
  input  wire logic                            DRV_TICK,
  input  wire logic                            ENV_VALID,
  input  wire logic [uecd_pkg::ENV_W-1:0]      ENV_FILT,
  input  wire logic [uecd_pkg::RAW_W-1:0]      ENV_RAW,
  input  wire logic [uecd_pkg::ENV_W-1:0]      ATG_LEVEL,
  input  wire logic                            RING_CMP,
  // Temperature converter
  input  wire logic                            TEMP_ADC_VALID,
  input  wire logic [uecd_pkg::TEMP_W-1:0]     TEMP_ADC,
  // Setup contents
  output var  uecd_pkg::uecd_meas_t            MEAS_SETUP,
  output var  logic [7:0]                      THRA_SETUP,
  output var  logic [7:0]                      THRB_SETUP,
  output var  logic [7:0]                      CAL_SETUP,
  // Results
  output var  uecd_pkg::uecd_status_t          STATUS,
  output var  logic [uecd_pkg::NRG_W-1:0]      NF_ENERGY,
  output var  logic [uecd_pkg::CNT_W-1:0]      NF_TCOMP,
  output var  logic [uecd_pkg::TEMP_W-1:0]     TEMP_CODE,
  output var  logic                            TEMP_READY
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] io_sync_reg;
  logic [1:0] cmp_sync_reg;

  // Pin inputs are asynchronous to CLOCK
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      io_sync_reg  <= 2'b11;
      cmp_sync_reg <= 2'b00;
    end else if (CE) begin
      io_sync_reg  <= {io_sync_reg[0], IO_IN};
      cmp_sync_reg <= {cmp_sync_reg[0], RING_CMP};
    end
  end

  wire io_low   = ~io_sync_reg[1];
  wire ring_cmp = cmp_sync_reg[1];

  // ----------------------------------------------------------------
  // Setup registers
  // ----------------------------------------------------------------
  uecd_pkg::uecd_meas_t meas_reg;
  logic [7:0]           thra_reg;
  logic [7:0]           thrb_reg;
  logic [7:0]           cal_reg;
  logic                 cal_loaded_reg;
  logic [2:0]           wr_ok_reg;

  // Write decode: only parity-clean transfers change a setup
  wire wr_good = SETUP_WR & SETUP_PARITY_OK;
  wire wr_meas = wr_good & (SETUP_SEL == uecd_pkg::SEL_MEAS);
  wire wr_thra = wr_good & (SETUP_SEL == uecd_pkg::SEL_THRA);
  wire wr_thrb = wr_good & (SETUP_SEL == uecd_pkg::SEL_THRB);
  wire wr_any  = SETUP_WR & (SETUP_SEL != 2'h3);

  // Defaults at reset, host overwrites later; all volatile
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      meas_reg <= uecd_pkg::uecd_meas_t'(uecd_pkg::MEAS_RESET);
      thra_reg <= uecd_pkg::THRA_RESET;
      thrb_reg <= uecd_pkg::THRB_RESET;
      wr_ok_reg <= 3'h0;
    end else if (CE) begin
      if (wr_meas) begin
        meas_reg <= uecd_pkg::uecd_meas_t'(SETUP_DATA);
      end
      if (wr_thra) begin
        thra_reg <= SETUP_DATA;
      end
      if (wr_thrb) begin
        thrb_reg <= SETUP_DATA;
      end
      if (wr_any) begin
        wr_ok_reg[SETUP_SEL] <= SETUP_PARITY_OK;
      end
    end
  end

  // Calibration is fetched from the cells in the first cycle after reset release
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      cal_reg        <= uecd_pkg::CAL_RESET;
      cal_loaded_reg <= 1'b0;
    end else if (CE && !cal_loaded_reg) begin
      cal_reg        <= NVM_CAL;
      cal_loaded_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencing
  // ----------------------------------------------------------------
  uecd_pkg::uecd_state_t state_reg;
  uecd_pkg::uecd_state_t state_next;

  wire in_idle  = (state_reg == uecd_pkg::ST_IDLE);
  wire in_noise = (state_reg == uecd_pkg::ST_NOISE);
  wire in_meas  = (state_reg == uecd_pkg::ST_MEAS);
  wire meas_end = in_meas & MEAS_END;

  // Host low phase opens the noise window; framer starts the measurement
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      uecd_pkg::ST_IDLE: begin
        if (io_low) begin
          state_next = uecd_pkg::ST_NOISE;
        end
      end
      uecd_pkg::ST_NOISE: begin
        if (MEAS_START) begin
          state_next = uecd_pkg::ST_MEAS;
        end else if (!io_low) begin
          state_next = uecd_pkg::ST_IDLE;
        end
      end
      uecd_pkg::ST_MEAS: begin
        if (MEAS_END) begin
          state_next = uecd_pkg::ST_IDLE;
        end
      end
      default: state_next = uecd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_reg <= uecd_pkg::ST_IDLE;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Noise checks
  // ----------------------------------------------------------------
  logic noise_pre_reg;
  logic noise_dur_reg;

  // Threshold by field code
  wire [uecd_pkg::ENV_W-1:0] noise_thr =
    (meas_reg.noise_cfg == 2'h0) ? uecd_pkg::NOISE_THR_00 :
    (meas_reg.noise_cfg == 2'h1) ? uecd_pkg::NOISE_THR_01 :
    (meas_reg.noise_cfg == 2'h2) ? uecd_pkg::NOISE_THR_10 : uecd_pkg::NOISE_THR_11;

  // Gained filter output is the compared quantity
  wire noise_hit = in_noise & ENV_VALID & (ENV_FILT > noise_thr);
  wire atg_hit   = in_meas & (ATG_LEVEL >= uecd_pkg::ATG_NOISE_LEVEL);
  wire noise_clr = in_idle & io_low;

  // Running flags; clear only on entry to the noise window, so no set is lost
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      noise_pre_reg <= 1'b0;
      noise_dur_reg <= 1'b0;
    end else if (CE) begin
      if (noise_hit) begin
        noise_pre_reg <= 1'b1;
      end else if (noise_clr) begin
        noise_pre_reg <= 1'b0;
      end
      if (atg_hit) begin
        noise_dur_reg <= 1'b1;
      end else if (noise_clr) begin
        noise_dur_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Echo detection
  // ----------------------------------------------------------------
  logic                   echo_reg;
  logic                   above_reg;
  logic                   rising_reg;
  logic                   fired_reg;
  logic [uecd_pkg::RAW_W-1:0] raw_prev_reg;
  logic                   ring_done_reg;
  logic                   deb_on_done;
  logic                   deb_off_done;
  logic                   short_done;

  wire [7:0] thr_sel   = meas_reg.thr_sel ? thrb_reg : thra_reg;
  wire       above_now = ENV_FILT > thr_sel;
  wire       every_md  = meas_reg.every_peak_enable;
  wire       first_md  = meas_reg.first_peak_enable & ~every_md;
  wire       peak_md   = every_md | first_md;
  wire       detect_on = in_meas & ring_done_reg;

  // Ungained height finds the maximum even when the filter output saturates
  wire raw_fall = ENV_RAW <= raw_prev_reg;
  wire peak_now = detect_on & ENV_VALID & above_now & rising_reg & raw_fall;

  // Drive-period debounce and short-pulse counters
  uecd_tick_count #(.LIMIT(uecd_pkg::DEB_ON_PERIODS)) u_deb_on (
    .clk  (CLOCK),
    .rst  (RESET),
    .ce   (CE),
    .clear(~(detect_on & above_reg) | echo_reg),
    .tick (DRV_TICK),
    .done (deb_on_done)
  );

  uecd_tick_count #(.LIMIT(uecd_pkg::DEB_OFF_PERIODS)) u_deb_off (
    .clk  (CLOCK),
    .rst  (RESET),
    .ce   (CE),
    .clear(above_reg | ~echo_reg),
    .tick (DRV_TICK),
    .done (deb_off_done)
  );

  uecd_tick_count #(.LIMIT(uecd_pkg::SHORT_PULSE_PERIODS)) u_short (
    .clk  (CLOCK),
    .rst  (RESET),
    .ce   (CE),
    .clear(~(echo_reg & every_md)),
    .tick (DRV_TICK),
    .done (short_done)
  );

  // Next state of the indication for each detection type
  wire width_set = ~peak_md & deb_on_done & ~echo_reg;
  wire width_clr = ~peak_md & deb_off_done;
  wire first_set = first_md & peak_now & ~fired_reg;
  wire first_clr = first_md & ENV_VALID & ~above_now;
  wire every_set = every_md & peak_now;
  wire every_clr = every_md & short_done;
  wire echo_next = detect_on &
                   (width_set | first_set | every_set | (echo_reg & ~(width_clr | first_clr | every_clr)));

  // Sample history for crossing and peak tracking
  always_ff @(posedge CLOCK) begin
    if (RESET || (CE && !in_meas)) begin
      above_reg    <= 1'b0;
      rising_reg   <= 1'b0;
      fired_reg    <= 1'b0;
      raw_prev_reg <= '0;
    end else if (CE && ENV_VALID) begin
      above_reg    <= above_now;
      raw_prev_reg <= ENV_RAW;
      rising_reg   <= (ENV_RAW > raw_prev_reg);
      fired_reg    <= above_now & (fired_reg | first_set);
    end
  end

  // Open-drain drive: low only while an indication stands
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      echo_reg <= 1'b0;
    end else if (CE) begin
      echo_reg <= echo_next;
    end
  end

  // ----------------------------------------------------------------
  // Ringing end and near-range energy
  // ----------------------------------------------------------------
  logic [uecd_pkg::CNT_W-1:0] samp_cnt_reg;
  logic [uecd_pkg::CNT_W-1:0] ring_time_reg;
  logic [uecd_pkg::NRG_W-1:0] energy_reg;

  // Comparator path bypasses gains and filter
  wire ring_end  = meas_reg.ringing_source_select ? ~ring_cmp : (ENV_VALID & ~above_now);
  wire in_window = samp_cnt_reg < uecd_pkg::NF_WINDOW_SAMPLES;

  // Detection is held off until ringing has died away
  always_ff @(posedge CLOCK) begin
    if (RESET || (CE && !in_meas)) begin
      ring_done_reg <= 1'b0;
      ring_time_reg <= '0;
      samp_cnt_reg  <= '0;
      energy_reg    <= '0;
    end else if (CE) begin
      if (!ring_done_reg && ring_end) begin
        ring_done_reg <= 1'b1;
        ring_time_reg <= samp_cnt_reg;
      end
      if (ENV_VALID && in_window) begin
        samp_cnt_reg <= samp_cnt_reg + uecd_pkg::CNT_W'(1);
        energy_reg   <= energy_reg + uecd_pkg::NRG_W'(ENV_FILT);
      end
    end
  end

  // ----------------------------------------------------------------
  // Temperature readout
  // ----------------------------------------------------------------
  localparam int TW = $clog2(TEMP_DELAY_CYCLES + 1);
  localparam logic [TW-1:0] TEMP_LIM = TW'(TEMP_DELAY_CYCLES);
  logic [TW-1:0] temp_cnt_reg;

  wire temp_ok = (temp_cnt_reg == TEMP_LIM);

  // Settle counter restarts on wake-up
  always_ff @(posedge CLOCK) begin
    if (RESET || (CE && WAKE)) begin
      temp_cnt_reg <= '0;
    end else if (CE && !temp_ok) begin
      temp_cnt_reg <= temp_cnt_reg + TW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Results latched per measurement serve both status paths
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      STATUS     <= '0;
      NF_ENERGY  <= '0;
      NF_TCOMP   <= '0;
      TEMP_CODE  <= '0;
      TEMP_READY <= 1'b0;
    end else if (CE) begin
      STATUS.wr_ok_meas <= wr_ok_reg[0];
      STATUS.wr_ok_thra <= wr_ok_reg[1];
      STATUS.wr_ok_thrb <= wr_ok_reg[2];
      if (meas_end) begin
        STATUS.noise_before <= noise_pre_reg;
        STATUS.noise_during <= noise_dur_reg | atg_hit;
        NF_ENERGY           <= energy_reg;
        NF_TCOMP            <= ring_time_reg;
      end
      TEMP_READY <= temp_ok & ~WAKE;
      if (temp_ok && TEMP_ADC_VALID) begin
        TEMP_CODE <= TEMP_ADC;
      end
    end
  end

  // Setup mirrors and the pin drive, all from flip-flops
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      MEAS_SETUP <= uecd_pkg::uecd_meas_t'(uecd_pkg::MEAS_RESET);
      THRA_SETUP <= uecd_pkg::THRA_RESET;
      THRB_SETUP <= uecd_pkg::THRB_RESET;
      CAL_SETUP  <= uecd_pkg::CAL_RESET;
      IO_OUT     <= 1'b0;
      IO_OE      <= 1'b0;
    end else if (CE) begin
      MEAS_SETUP <= meas_reg;
      THRA_SETUP <= thra_reg;
      THRB_SETUP <= thrb_reg;
      CAL_SETUP  <= cal_reg;
      IO_OUT     <= 1'b0;
      IO_OE      <= echo_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_io_release: assert property (CE && !in_meas |=> !IO_OE)
    else $error("IO driven outside a measurement");
  a_width_debounce: assert property ($rose(echo_reg) && !peak_md |-> $past(deb_on_done))
    else $error("width echo asserted before debounce");
  a_release_debounce: assert property ($fell(echo_reg) && !peak_md && in_meas |-> $past(deb_off_done))
    else $error("width echo released before trailing debounce");
  a_peak_at_once: assert property (CE && every_md && peak_now && !echo_reg |=> IO_OE ##1 echo_reg)
    else $error("peak not signalled at once");
  a_short_pulse: assert property (CE && every_clr && !every_set && in_meas |=> !echo_reg)
    else $error("every-peak pulse not shortened");
  a_noise_table: assert property (meas_reg.noise_cfg == 2'h2 |-> noise_thr == 8'h40)
    else $error("noise threshold wrong for code 2");
  a_atg_flag: assert property (CE && atg_hit ##1 CE && meas_end |=> STATUS.noise_during)
    else $error("adaptive threshold noise not reported");
  a_noise_latch: assert property (CE && meas_end |=> STATUS.noise_before == $past(noise_pre_reg))
    else $error("pre-measurement noise not latched");
  a_cal_load: assert property ($rose(cal_loaded_reg) |-> cal_reg == $past(NVM_CAL))
    else $error("calibration not loaded from cells");
  a_wr_record: assert property (CE && SETUP_WR && SETUP_SEL == 2'h1 |=> wr_ok_reg[1] == $past(SETUP_PARITY_OK))
    else $error("write result not recorded");
  a_temp_delay: assert property (TEMP_READY |-> $past(temp_ok))
    else $error("temperature ready before settle delay");

  c_width_echo: cover property (!peak_md && $rose(echo_reg));
  c_every_peak: cover property (every_md && $rose(echo_reg) ##[1:200] $fell(echo_reg));
  c_noise_seen: cover property (meas_end && noise_pre_reg);
  c_temp_ready: cover property ($rose(TEMP_READY));

endmodule
`default_nettype wire

/* dv/uecd_host.sv */
// Host control unit model on the open-drain IO line
`timescale 1ns/1ps
`default_nettype none
module uecd_host (
  // Device side
  input  wire logic dev_oe,
  // Host request
  input  wire logic hold_low,
  // Line level, host pull-up
  output logic      line
);
  // Pull-up restores high once neither party pulls low
  assign line = ~(dev_oe | hold_low);
endmodule
`default_nettype wire

/* dv/tb_uecd_top.sv */
// Self-checking bench of the echo detector back end
`timescale 1ns/1ps
`default_nettype none
module tb_uecd_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                   clock, reset, hold_low, io_line, io_out, io_oe, t_ready, ring;
  logic                   meas_start, meas_end, wake, setup_wr, par_ok, drv_tick, env_valid, t_valid;
  logic [1:0]             sel;
  logic [7:0]             sdata, nvm, filt, adaptive_threshold, thra, thrb, cal;
  logic [9:0]             raw, t_adc, t_code, nf_t;
  logic [15:0]            nf_e;
  uecd_pkg::uecd_meas_t   meas;
  uecd_pkg::uecd_status_t stat;
  int                     errors, n_checks;
  // Small settle count keeps the run short
  uecd_top #(.TEMP_DELAY_CYCLES(20)) uecd_top_i (
    .CLOCK(clock), .RESET(reset), .CE(1'b1), .IO_IN(io_line), .IO_OUT(io_out), .IO_OE(io_oe),
    .MEAS_START(meas_start), .MEAS_END(meas_end), .WAKE(wake), .SETUP_WR(setup_wr), .SETUP_SEL(sel),
    .SETUP_DATA(sdata), .SETUP_PARITY_OK(par_ok), .NVM_CAL(nvm), .DRV_TICK(drv_tick),
    .ENV_VALID(env_valid), .ENV_FILT(filt), .ENV_RAW(raw), .ATG_LEVEL(adaptive_threshold), .RING_CMP(ring),
    .TEMP_ADC_VALID(t_valid), .TEMP_ADC(t_adc), .MEAS_SETUP(meas), .THRA_SETUP(thra),
    .THRB_SETUP(thrb), .CAL_SETUP(cal), .STATUS(stat), .NF_ENERGY(nf_e), .NF_TCOMP(nf_t),
    .TEMP_CODE(t_code), .TEMP_READY(t_ready));
  uecd_host uecd_host_i (.dev_oe(io_oe), .hold_low(hold_low), .line(io_line));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Inputs move 1 ns after the edge, outputs read then too
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d, input logic p);
    setup_wr = 1'b1;
    sel = s;
    sdata = d;
    par_ok = p;
    cyc(1);
    setup_wr = 1'b0;
    cyc(2);
  endtask
  task automatic sample(input logic [7:0] f, input logic [9:0] r);
    filt = f;
    raw = r;
    env_valid = 1'b1;
    cyc(1);
    env_valid = 1'b0;
    cyc(1);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      drv_tick = 1'b1;
      cyc(1);
      drv_tick = 1'b0;
      cyc(1);
    end
  endtask
  // Host holds IO low, one noise sample, then the command starts
  task automatic start_meas(input logic [7:0] noise);
    hold_low = 1'b1;
    cyc(4);
    sample(noise, 10'h000);
    meas_start = 1'b1;
    cyc(1);
    meas_start = 1'b0;
    hold_low = 1'b0;
    cyc(1);
  endtask
  task automatic end_meas();
    meas_end = 1'b1;
    cyc(1);
    meas_end = 1'b0;
    cyc(1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(meas, 8'h04);
    chk(thra, 8'h40);
    chk(thrb, 8'h60);
    chk(cal, 8'hA5);
    chk(stat, 5'h00);
    chk(io_oe, 1'b0);
    $display("done reset");
  endtask
  // Good write, bad parity write, write to the unused target
  task automatic t_write();
    wr(2'h1, 8'h50, 1'b1);
    wr(2'h2, 8'h70, 1'b0);
    wr(2'h3, 8'hFF, 1'b1);
    chk(thra, 8'h50);
    chk(thrb, 8'h60);
    chk(stat[2:0], 3'h2);
    $display("done write");
  endtask
  // Each noise code at its threshold and just above it
  task automatic t_noise();
    logic [7:0] thr;
    for (int c = 0; c < 4; c++) begin
      wr(2'h0, {6'h00, c[1:0]}, 1'b1);
      thr = 8'h10 << c;
      start_meas(thr);
      end_meas();
      chk(stat[3], 1'b0);
      start_meas(thr + 8'h01);
      end_meas();
      chk(stat[3], 1'b1);
    end
    $display("done noise");
  endtask
  // Width mode: 3 period accept, 16 period release, noise during
  task automatic t_width();
    wr(2'h0, 8'h00, 1'b1);
    adaptive_threshold = 8'h80;
    start_meas(8'h00);
    sample(8'h10, 10'h010);
    sample(8'h60, 10'h060);
    ticks(2);
    chk(io_oe, 1'b0);
    ticks(1);
    cyc(2);
    chk(io_oe, 1'b1);
    chk(io_out, 1'b0);
    chk(io_line, 1'b0);
    sample(8'h20, 10'h020);
    ticks(15);
    chk(io_oe, 1'b1);
    ticks(1);
    cyc(2);
    chk(io_oe, 1'b0);
    end_meas();
    chk(stat[4], 1'b1);
    chk(nf_e, 16'h0090);
    chk(nf_t, 10'h000);
    adaptive_threshold = 8'h00;
    $display("done width");
  endtask
  // Saturated filter output: only the raw height shows the peak
  task automatic t_peak();
    wr(2'h0, 8'h04, 1'b1);
    start_meas(8'h00);
    sample(8'h10, 10'h010);
    sample(8'hFF, 10'h100);
    sample(8'hFF, 10'h200);
    chk(io_oe, 1'b0);
    sample(8'hFF, 10'h200);
    chk(io_oe, 1'b1);
    sample(8'h20, 10'h020);
    chk(io_oe, 1'b0);
    end_meas();
    chk(stat[4], 1'b0);
    $display("done peak");
  endtask
  // Every-peak on the second threshold; comparator, not envelope, ends ringing
  task automatic t_every();
    wr(2'h0, 8'h38, 1'b1);
    chk(meas, 8'h38);
    chk(stat[0], 1'b1);
    start_meas(8'h00);
    sample(8'h80, 10'h080);
    sample(8'h58, 10'h058);
    ring = 1'b0;
    cyc(3);
    sample(8'h70, 10'h070);
    sample(8'h5C, 10'h05C);
    chk(io_oe, 1'b0);
    sample(8'h90, 10'h090);
    sample(8'h90, 10'h090);
    chk(io_oe, 1'b1);
    ticks(3);
    chk(io_oe, 1'b1);
    ticks(1);
    chk(io_oe, 1'b0);
    sample(8'hA0, 10'h0A0);
    sample(8'hA0, 10'h0A0);
    chk(io_oe, 1'b1);
    end_meas();
    chk(io_oe, 1'b0);
    chk(nf_e, 16'h0404);
    chk(nf_t, 10'h002);
    ring = 1'b1;
    $display("done every");
  endtask
  task automatic t_temp();
    chk(t_ready, 1'b1);
    t_adc = 10'h2C5;
    t_valid = 1'b1;
    cyc(1);
    t_valid = 1'b0;
    cyc(1);
    chk(t_code, 10'h2C5);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    cyc(2);
    chk(t_ready, 1'b0);
    cyc(25);
    chk(t_ready, 1'b1);
    $display("done temp");
  endtask
  // ----------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #2000000;
    errors++;
    wrap_up();
  end
  initial begin
    {reset, hold_low, meas_start, meas_end, wake, setup_wr, par_ok, drv_tick, env_valid, t_valid} = '0;
    reset = 1'b1;
    {sel, sdata, filt, adaptive_threshold, raw, t_adc} = '0;
    nvm = 8'hA5;
    ring = 1'b1;
    errors = 0;
    n_checks = 0;
    cyc(6);
    reset = 1'b0;
    cyc(3);
    t_reset();
    t_write();
    t_noise();
    t_width();
    t_peak();
    t_every();
    t_temp();
    wrap_up();
  end
endmodule
`default_nettype wire
